// File: src/pio_top.sv
// Parallel port block: AXI4-Lite register front end, ports 0 and 1 with their
// pin logic, and plain output latches for ports 2 to 7.
// Assumes pins and peripheral outputs are synchronous to aclk.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pio_consts.svh"
module pio_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port0_pin_in,
  input wire logic [7:0] port0_periph_out,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_pin_oe,
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] port1_periph_out,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe,
  output logic [5:0][7:0] portx_out
);

  pio_port_if p0_if ();
  pio_port_if p1_if ();

  pio_pkg::pio_wr_state_e wstate_q;
  pio_pkg::pio_rd_state_e rstate_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] widx_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] ridx;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic [7:0] bitop_val;
  logic [5:0][7:0] xlatch_q;

  // Register index from a byte address; low two bits select a byte lane only.
  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'(addr);
    return wide[9:2];
  endfunction

  // Implemented bits of ports 2 to 7; unused upper bits stay zero.
  function automatic logic [7:0] port_mask(input int n);
    logic [7:0] m;
    m = 8'hFF;
    if (n == 2) begin
      m = 8'((1 << `PIO_P2_W) - 1);
    end else if (n == 5) begin
      m = 8'((1 << `PIO_P5_W) - 1);
    end
    return m;
  endfunction

  // Whether an index names a register that takes a write.
  function automatic logic wr_mapped(input logic [7:0] idx);
    return (idx <= `PIO_IDX_P7_LATCH) || (idx == `PIO_IDX_P0_DRIVE)
      || (idx == `PIO_IDX_P1_DIR) || (idx == `PIO_IDX_P1_BITOP);
  endfunction

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  // Address and data are taken in either order while no write is in progress.
  assign s_axi_awready = (wstate_q == pio_pkg::PIO_WR_IDLE) && !aw_have_q;
  assign s_axi_wready = (wstate_q == pio_pkg::PIO_WR_IDLE) && !w_have_q;
  assign s_axi_bvalid = (wstate_q == pio_pkg::PIO_WR_RESP);
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = (rstate_q == pio_pkg::PIO_RD_IDLE);
  assign s_axi_rvalid = (rstate_q == pio_pkg::PIO_RD_RESP);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write address holding.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      widx_q <= 8'h00;
    end else if (aw_hs) begin
      aw_have_q <= 1'b1;
      widx_q <= reg_idx(s_axi_awaddr);
    end else if (wstate_q == pio_pkg::PIO_WR_S1) begin
      aw_have_q <= 1'b0;
    end
  end

  // Write data holding; only byte lane 0 carries register bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (w_hs) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata[7:0];
      wlane_q <= s_axi_wstrb[0];
    end else if (wstate_q == pio_pkg::PIO_WR_S1) begin
      w_have_q <= 1'b0;
    end
  end

  // Write sequence: decode in S1, outputs change in S2, then the response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_q <= pio_pkg::PIO_WR_IDLE;
      bresp_q <= `PIO_RESP_OKAY;
    end else begin
      unique case (wstate_q)
        pio_pkg::PIO_WR_IDLE: begin
          if ((aw_have_q || aw_hs) && (w_have_q || w_hs)) begin
            wstate_q <= pio_pkg::PIO_WR_S1;
          end
        end
        pio_pkg::PIO_WR_S1: begin
          bresp_q <= wr_mapped(widx_q) ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
          wstate_q <= pio_pkg::PIO_WR_S2;
        end
        pio_pkg::PIO_WR_S2: begin
          wstate_q <= pio_pkg::PIO_WR_RESP;
        end
        pio_pkg::PIO_WR_RESP: begin
          if (s_axi_bready) begin
            wstate_q <= pio_pkg::PIO_WR_IDLE;
          end
        end
      endcase
    end
  end

  // Register strobes fire only in the S2 state; a cleared lane 0 writes nothing.
  assign do_wr = (wstate_q == pio_pkg::PIO_WR_S2) && wlane_q;
  // Bit operation reads the mixed view first, so input bits copy their pins.
  always_comb begin
    bitop_val = p1_if.readback;
    bitop_val[wdata_q[`PIO_BITOP_NUM_LSB +: 3]] = wdata_q[`PIO_BITOP_VAL_BIT];
  end
  assign p0_if.wr_latch = do_wr && (widx_q == `PIO_IDX_P0_LATCH);
  assign p0_if.wr_ctrl = do_wr && (widx_q == `PIO_IDX_P0_DRIVE);
  assign p0_if.wdata = wdata_q;
  assign p1_if.wr_latch = do_wr && ((widx_q == `PIO_IDX_P1_LATCH)
    || (widx_q == `PIO_IDX_P1_BITOP));
  assign p1_if.wr_ctrl = do_wr && (widx_q == `PIO_IDX_P1_DIR);
  assign p1_if.wdata = (widx_q == `PIO_IDX_P1_BITOP) ? bitop_val : wdata_q;

  // Plain output latches of ports 2 to 7; ports 2 to 5 reset high, 6 and 7 low.
  always_ff @(posedge aclk) begin
    for (int n = 2; n < 8; n++) begin
      if (!aresetn) begin
        xlatch_q[n-2] <= (n < 6) ? (`PIO_HI_LATCH_RST & port_mask(n)) : `PIO_LO_LATCH_RST;
      end else if (do_wr && (widx_q == 8'(n))) begin
        xlatch_q[n-2] <= wdata_q & port_mask(n);
      end
    end
  end
  assign portx_out = xlatch_q;

  assign ridx = reg_idx(s_axi_araddr);

  // Read sequence: the register view, pins included, is captured in S1.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate_q <= pio_pkg::PIO_RD_IDLE;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PIO_RESP_OKAY;
    end else begin
      unique case (rstate_q)
        pio_pkg::PIO_RD_IDLE: begin
          if (ar_hs) begin
            rstate_q <= pio_pkg::PIO_RD_S1;
            rdata_q[15:8] <= ridx;
          end
        end
        pio_pkg::PIO_RD_S1: begin
          rstate_q <= pio_pkg::PIO_RD_RESP;
          rresp_q <= `PIO_RESP_OKAY;
          rdata_q <= 32'h0000_0000;
          if (rdata_q[15:8] == `PIO_IDX_P0_LATCH) begin
            rdata_q[7:0] <= p0_if.latch;
          end else if (rdata_q[15:8] == `PIO_IDX_P0_PIN) begin
            rdata_q[7:0] <= p0_if.readback;
          end else if (rdata_q[15:8] == `PIO_IDX_P1_LATCH) begin
            rdata_q[7:0] <= p1_if.readback;
          end else if (rdata_q[15:8] == `PIO_IDX_P0_DRIVE) begin
            rdata_q[7:0] <= p0_if.ctrl;
          end else if (rdata_q[15:8] == `PIO_IDX_P1_DIR) begin
            rdata_q[7:0] <= p1_if.ctrl;
          end else if ((rdata_q[15:8] >= `PIO_IDX_P2_LATCH)
                       && (rdata_q[15:8] <= `PIO_IDX_P7_LATCH)) begin
            rdata_q[7:0] <= xlatch_q[3'(rdata_q[15:8] - `PIO_IDX_P2_LATCH)];
          end else begin
            rresp_q <= `PIO_RESP_SLVERR;
          end
        end
        pio_pkg::PIO_RD_RESP: begin
          if (s_axi_rready) begin
            rstate_q <= pio_pkg::PIO_RD_IDLE;
          end
        end
        default: begin
          rstate_q <= pio_pkg::PIO_RD_IDLE;
        end
      endcase
    end
  end

  pio_port0 u_port0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(p0_if.port),
    .pin_in(port0_pin_in),
    .periph_out(port0_periph_out),
    .pin_out(port0_pin_out),
    .pin_oe(port0_pin_oe)
  );

  pio_port1 u_port1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(p1_if.port),
    .pin_in(port1_pin_in),
    .periph_out(port1_periph_out),
    .pin_out(port1_pin_out),
    .pin_oe(port1_pin_oe)
  );

  // Outputs change only at the edge that ends S2.
  out_after_s2_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(p0_if.latch) |-> $past(wstate_q) == pio_pkg::PIO_WR_S2)
    else $error("port 0 latch changed outside S2");
  pin_sample_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rstate_q == pio_pkg::PIO_RD_S1) && (rdata_q[15:8] == `PIO_IDX_P0_PIN)
      |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(port0_pin_in)))
    else $error("pin read not sampled in S1");
  bitop_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr && (widx_q == `PIO_IDX_P1_BITOP)
      |=> ((p1_if.latch & ~$past(p1_if.ctrl) & ~(8'h01 << $past(wdata_q[2:0])))
        == ($past(port1_pin_in) & ~$past(p1_if.ctrl) & ~(8'h01 << $past(wdata_q[2:0]))))
        && (((p1_if.latch >> $past(wdata_q[2:0])) & 8'h01)
          == {7'h00, $past(wdata_q[3])}))
    else $error("bit operation did not copy input pins");
  port2_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (xlatch_q[0][7:3] == 5'h00) && (xlatch_q[3][7:5] == 3'h0))
    else $error("narrow port holds bits above its width");
  wr_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wstate_q == pio_pkg::PIO_WR_S1) |=> (wstate_q == pio_pkg::PIO_WR_S2)
      ##1 s_axi_bvalid)
    else $error("write response not two cycles after S1");
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  wr_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    p0_if.wr_ctrl ##[1:20] p0_if.wr_latch);
  rd_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready && (s_axi_rresp == `PIO_RESP_OKAY));
  bitop_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    do_wr && (widx_q == `PIO_IDX_P1_BITOP) && (p1_if.ctrl != 8'hFF));
endmodule

// File: src/pio_consts.svh
// Constants for the parallel port block: register indices, reset values, widths.
// Assumes inclusion by bare name from the design modules and the testbench.
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

// Register indices; the AXI byte address is four times the index.
`define PIO_IDX_P0_LATCH 8'h00
`define PIO_IDX_P1_LATCH 8'h01
`define PIO_IDX_P2_LATCH 8'h02
`define PIO_IDX_P7_LATCH 8'h07
`define PIO_IDX_P0_DRIVE 8'h08
`define PIO_IDX_P1_DIR 8'h09
`define PIO_IDX_P0_PIN 8'h0B
`define PIO_IDX_P1_BITOP 8'h10

// Bit operation register fields: bit number and the value to place there.
`define PIO_BITOP_NUM_LSB 0
`define PIO_BITOP_VAL_BIT 3

// Reset values.
`define PIO_P0_LATCH_RST 8'hFF
`define PIO_P0_DRIVE_RST 8'h00
`define PIO_P1_LATCH_RST 8'h00
`define PIO_P1_DIR_RST 8'h00
`define PIO_HI_LATCH_RST 8'hFF
`define PIO_LO_LATCH_RST 8'h00

// Port widths for ports 2 to 7; ports 0 and 1 are eight bits.
`define PIO_P2_W 3
`define PIO_P5_W 5
`define PIO_FULL_W 8

// AXI responses.
`define PIO_RESP_OKAY 2'h0
`define PIO_RESP_SLVERR 2'h2

`endif

// File: src/pio_pkg.sv
// Types shared by the parallel port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package pio_pkg;

  // Write sequence: address decode state, then the output update state.
  typedef enum logic [1:0] {
    PIO_WR_IDLE = 2'h0,
    PIO_WR_S1 = 2'h1,
    PIO_WR_S2 = 2'h3,
    PIO_WR_RESP = 2'h2
  } pio_wr_state_e;

  // Read sequence: the sample state, then the data phase.
  typedef enum logic [1:0] {
    PIO_RD_IDLE = 2'h0,
    PIO_RD_S1 = 2'h1,
    PIO_RD_RESP = 2'h3
  } pio_rd_state_e;

  typedef logic [7:0] pio_byte_t;

endpackage

// File: src/pio_port_if.sv
// Register-side connection between the bus front end and one port.
// Assumes one clock domain; strobes are single-cycle pulses.
`timescale 1ns/1ps
interface pio_port_if;
  logic wr_latch;
  logic wr_ctrl;
  pio_pkg::pio_byte_t wdata;
  pio_pkg::pio_byte_t latch;
  pio_pkg::pio_byte_t ctrl;
  pio_pkg::pio_byte_t readback;

  modport ctl (output wr_latch, output wr_ctrl, output wdata,
               input latch, input ctrl, input readback);
  modport port (input wr_latch, input wr_ctrl, input wdata,
                output latch, output ctrl, output readback);
endinterface

// File: src/pio_port0.sv
// Port 0: output latch, per-bit open-drain or push-pull drive, live pin readback.
// Assumes pins are synchronous to aclk and peripheral outputs idle high.
`timescale 1ns/1ps
`include "pio_consts.svh"
module pio_port0 (
  input wire logic aclk,
  input wire logic aresetn,
  pio_port_if.port bus,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] periph_out,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe
);

  logic [7:0] latch_q;
  logic [7:0] drive_q;
  logic [7:0] level;

  // Output latch; holds the driven value between writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= `PIO_P0_LATCH_RST;
    end else if (bus.wr_latch) begin
      latch_q <= bus.wdata;
    end
  end

  // Drive-type control, cleared to open drain at reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_q <= `PIO_P0_DRIVE_RST;
    end else if (bus.wr_ctrl) begin
      drive_q <= bus.wdata;
    end
  end

  // A shared peripheral can only pull a bit low when its latch is one.
  assign level = latch_q & periph_out;
  assign pin_out = level;
  // Open drain only enables the driver while sinking, so a latched one floats.
  assign pin_oe = drive_q | ~level;
  assign bus.latch = latch_q;
  assign bus.ctrl = drive_q;
  // Pins are not latched: the value is taken at the moment of the read.
  assign bus.readback = pin_in;

  // A drive-type write must show on the enables at once: open-drain bits only sink.
  open_drain_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bus.wr_ctrl |=> ((pin_oe & ~$past(bus.wdata) & pin_out) == 8'h00)
      && ((pin_oe & $past(bus.wdata)) == $past(bus.wdata)))
    else $error("open-drain bit drives high");
  p0_reset_a: assert property (@(posedge aclk)
    !aresetn |=> (latch_q == 8'hFF) && (drive_q == 8'h00))
    else $error("port 0 reset values wrong");
  p0_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bus.wr_latch && bus.wr_ctrl == 1'b0 && (bus.wdata == 8'hFF)
      && (periph_out == 8'hFF) |=> (pin_oe == drive_q))
    else $error("open-drain port with latch ones still drives");
endmodule

// File: src/pio_port1.sv
// Port 1: output latch, per-bit direction, mixed latch/pin readback.
// Assumes pins are synchronous to aclk and peripheral outputs idle high.
`timescale 1ns/1ps
`include "pio_consts.svh"
module pio_port1 (
  input wire logic aclk,
  input wire logic aresetn,
  pio_port_if.port bus,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] periph_out,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe
);

  logic [7:0] latch_q;
  logic [7:0] dir_q;

  // Output latch, cleared at reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= `PIO_P1_LATCH_RST;
    end else if (bus.wr_latch) begin
      latch_q <= bus.wdata;
    end
  end

  // Direction control; zero at reset leaves every pin an input.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= `PIO_P1_DIR_RST;
    end else if (bus.wr_ctrl) begin
      dir_q <= bus.wdata;
    end
  end

  // A latched zero forces low; a latched one passes the timer or divider output.
  assign pin_out = latch_q & periph_out;
  assign pin_oe = dir_q;
  assign bus.latch = latch_q;
  assign bus.ctrl = dir_q;
  // Output bits read their latch, input bits read the live pin.
  assign bus.readback = (dir_q & latch_q) | (~dir_q & pin_in);

  p1_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bus.wr_ctrl |=> pin_oe == $past(bus.wdata))
    else $error("direction write not reflected on enables");
  p1_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bus.wr_latch |=> ((pin_out & ~$past(bus.wdata)) == 8'h00))
    else $error("output bit with latch zero drives high");
  p1_reset_a: assert property (@(posedge aclk)
    !aresetn |=> (pin_oe == 8'h00) && (latch_q == 8'h00))
    else $error("port 1 reset values wrong");
endmodule

// File: tb/pio_pin_model.sv
// Model of the board side of one eight-bit port: a pull-up on every line
// and an outside source that may drive each line while the port lets go.
// Assumes pin_oe high means the port drives the line.
`timescale 1ns/1ps
module pio_pin_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  // Each line resolves to the port's level, the outside level, or the pull-up.
  // The outside source is a plain level that changes only when the bench sets it, and so
  // needs no debounce in the bench.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = 1'h1; // Pull-up, so a released line never floats.
      end
    end
  end
endmodule

// File: tb/parallel_io_ports_p0_p1_tb.sv
// Self-checking bench for the parallel port block, driven over AXI4-Lite.
// Assumes the block answers every request; a cycle ceiling cuts a hang short.
`timescale 1ns/1ps
`include "pio_consts.svh"
module parallel_io_ports_p0_p1_tb;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] p0_in, p0_per, p0_out, p0_oe, p1_in, p1_per, p1_out, p1_oe;
  logic [7:0] ext0, ext0_en, ext1, ext1_en;
  logic [5:0][7:0] portx;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;

  pio_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port0_pin_in(p0_in), .port0_periph_out(p0_per), .port0_pin_out(p0_out),
    .port0_pin_oe(p0_oe), .port1_pin_in(p1_in), .port1_periph_out(p1_per),
    .port1_pin_out(p1_out), .port1_pin_oe(p1_oe), .portx_out(portx));

  pio_pin_model pins0 (.pin_out(p0_out), .pin_oe(p0_oe), .ext_val(ext0), .ext_en(ext0_en),
    .pin_in(p0_in));
  pio_pin_model pins1 (.pin_out(p1_out), .pin_oe(p1_oe), .ext_val(ext1), .ext_en(ext1_en),
    .pin_in(p1_in));

  // Free-running 250 MHz clock.
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  // Cycle ceiling; a hung handshake counts as a mismatch.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Handshakes are judged at the rising edge itself, on the values the design
  // samples there; each channel is released only after its own handshake edge.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st);
    logic done;
    @(posedge aclk);
    awaddr <= {idx[5:0], 2'h0};
    wdata <= {24'h000000, d};
    wstrb <= st;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    done = 1'h0;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        resp = bresp;
        done = 1'h1;
      end
    end
  endtask

  task automatic rdt(input logic [7:0] idx);
    logic done;
    @(posedge aclk);
    araddr <= {idx[5:0], 2'h0};
    arvalid <= 1'h1;
    done = 1'h0;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        rd = rdata;
        resp = rresp;
        done = 1'h1;
      end
    end
  endtask

  task automatic wrc(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    wr(idx, d, 4'hF);
    chk(resp, er);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    rdt(idx);
    chk(rd, ed);
    chk(resp, er);
  endtask

  // Expected level of a line under the pin model, worked out independently.
  function automatic logic [7:0] lvl(input logic [7:0] o, oe, e, en);
    return (oe & o) | (~oe & en & e) | (~oe & ~en);
  endfunction

  // Main sequence: reset state, port 0, port 1, refusals, then ports 2 to 7.
  initial begin
    aresetn = 1'h0;
    {awaddr, araddr, awvalid, wvalid, arvalid} = '0;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    bready = 1'h1;
    rready = 1'h1;
    p0_per = 8'hFF;
    p1_per = 8'hFF;
    ext0 = 8'h33;
    ext0_en = 8'hFF;
    ext1 = 8'h3C;
    ext1_en = 8'hFF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(p0_out, 8'hFF);
    chk(p0_oe, 8'h00);
    chk(p1_oe, 8'h00);
    chk(p1_out, 8'h00);
    chk(portx, 48'h00001FFFFF07);
    rdc(`PIO_IDX_P0_LATCH, 32'h000000FF, `PIO_RESP_OKAY);
    rdc(`PIO_IDX_P0_DRIVE, 32'h00000000, `PIO_RESP_OKAY);
    rdc(`PIO_IDX_P1_DIR, 32'h00000000, `PIO_RESP_OKAY);
    rdc(`PIO_IDX_P1_LATCH, 32'h0000003C, `PIO_RESP_OKAY);
    // Port 0: latch first, then the drive type, as inputs require.
    wrc(`PIO_IDX_P0_LATCH, 8'h5A, `PIO_RESP_OKAY);
    wrc(`PIO_IDX_P0_DRIVE, 8'h0F, `PIO_RESP_OKAY);
    chk(p0_out, 8'h5A);
    chk(p0_oe, 8'hAF);
    rdc(`PIO_IDX_P0_LATCH, 32'h0000005A, `PIO_RESP_OKAY);
    rdc(`PIO_IDX_P0_PIN, {24'h0, lvl(8'h5A, 8'hAF, ext0, ext0_en)}, `PIO_RESP_OKAY);
    ext0 <= 8'hCC;
    rdc(`PIO_IDX_P0_PIN, {24'h0, lvl(8'h5A, 8'hAF, 8'hCC, 8'hFF)}, `PIO_RESP_OKAY);
    ext0_en <= 8'h0F;
    rdc(`PIO_IDX_P0_PIN, {24'h0, lvl(8'h5A, 8'hAF, 8'hCC, 8'h0F)}, `PIO_RESP_OKAY);
    p0_per <= 8'hFD;
    @(posedge aclk);
    chk(p0_out, 8'h58);
    chk(p0_oe, 8'hAF);
    p0_per <= 8'hFF;
    // Port 1: latch set before direction, mixed read, peripheral gating.
    wrc(`PIO_IDX_P1_LATCH, 8'hA5, `PIO_RESP_OKAY);
    wrc(`PIO_IDX_P1_DIR, 8'hF0, `PIO_RESP_OKAY);
    chk(p1_oe, 8'hF0);
    chk(p1_out, 8'hA5);
    rdc(`PIO_IDX_P1_LATCH, 32'h000000AC, `PIO_RESP_OKAY);
    p1_per <= 8'h7F;
    @(posedge aclk);
    chk(p1_out, 8'h25);
    p1_per <= 8'hFF;
    // Clearing bit 7 by bit operation copies input pins into the latch.
    wrc(`PIO_IDX_P1_BITOP, 8'h07, `PIO_RESP_OKAY);
    wrc(`PIO_IDX_P1_DIR, 8'hFF, `PIO_RESP_OKAY);
    chk(p1_out, 8'h2C);
    rdc(`PIO_IDX_P1_LATCH, 32'h0000002C, `PIO_RESP_OKAY);
    // Refusals: read-only and unmapped places, and a write with no strobe.
    wrc(`PIO_IDX_P0_PIN, 8'h00, `PIO_RESP_SLVERR);
    rdc(`PIO_IDX_P1_BITOP, 32'h00000000, `PIO_RESP_SLVERR);
    rdc(8'h3F, 32'h00000000, `PIO_RESP_SLVERR);
    wr(`PIO_IDX_P0_LATCH, 8'h00, 4'h0);
    chk(resp, `PIO_RESP_OKAY);
    rdc(`PIO_IDX_P0_LATCH, 32'h0000005A, `PIO_RESP_OKAY);
    // Port 0 bits back to inputs: latch ones first, then open drain.
    wrc(`PIO_IDX_P0_LATCH, 8'hFF, `PIO_RESP_OKAY);
    chk(p0_oe, 8'h0F);
    wrc(`PIO_IDX_P0_DRIVE, 8'h00, `PIO_RESP_OKAY);
    chk(p0_oe, 8'h00);
    rdc(`PIO_IDX_P0_PIN, {24'h0, lvl(8'hFF, 8'h00, 8'hCC, 8'h0F)}, `PIO_RESP_OKAY);
    // A late bready must leave the write response standing until taken.
    bready <= 1'h0;
    fork
      wrc(8'h03, 8'h55, `PIO_RESP_OKAY);
      begin
        repeat (6) @(posedge aclk);
        bready <= 1'h1;
      end
    join
    chk(portx[1], 8'h55);
    // Ports 2 to 7 keep only the bits their widths allow.
    for (int i = 0; i < 6; i++) begin
      wrc(8'(i + 2), 8'hAA, `PIO_RESP_OKAY);
      chk(portx[i], (i == 0) ? 8'h02 : (i == 3) ? 8'h0A : 8'hAA);
    end
    give_verdict();
  end
endmodule
